// ==== logic/fpw_pkg.sv ====
// shared constants, types and helpers of the flash program/erase/wrap sequencer
package fpw_pkg;

  // ----------------------------------------------------------------
  // clock and command codes
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam logic [7:0] OPC_WRITE_ENABLE_COMMAND = 8'h06;
  localparam logic [7:0] OPC_WRAP = 8'h77;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_QPROG = 8'h32;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_HALF = 8'h52;
  localparam logic [7:0] OPC_FULL = 8'hD8;

  // ----------------------------------------------------------------
  // bit counts of the serial phases
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] DUMMY_BITS = 6'h18;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] STEP_SINGLE = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;

  // ----------------------------------------------------------------
  // field positions and address masks
  // ----------------------------------------------------------------
  localparam int WRAP_OFF_BIT = 4;
  localparam int WRAP_LEN_LSB = 5;
  localparam int WRAP_LEN_MSB = 6;
  localparam int BP_BOTTOM_BIT = 3;
  localparam int BP_SMALL_BIT = 4;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [2:0] BP_ONE = 3'h1;
  localparam logic [23:0] PAGE_MASK = 24'h0000FF;
  localparam logic [23:0] SECT_MASK = 24'h000FFF;
  localparam logic [23:0] HALF_MASK = 24'h007FFF;
  localparam logic [23:0] FULL_MASK = 24'h00FFFF;
  localparam logic [23:0] SMALL_UNIT = 24'h001000;
  localparam logic [23:0] BIG_UNIT = 24'h010000;
  localparam logic [23:0] WRAP_MIN_LEN = 24'h000008;
  localparam logic [23:0] ONE_24 = 24'h000001;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    PH_OPC = 7'h01, PH_ADDR = 7'h02, PH_DUMMY = 7'h04, PH_WBYTE = 7'h08,
    PH_DATA = 7'h10, PH_TAIL = 7'h20, PH_SKIP = 7'h40
  } fpw_phase_t;
  typedef enum logic [2:0] {CY_IDLE = 3'h1, CY_FILL = 3'h2, CY_WAIT = 3'h4} fpw_cyc_t;
  typedef enum logic [1:0] {ER_SECT = 2'h0, ER_HALF = 2'h1, ER_FULL = 2'h2} fpw_erase_t;

  // protected region is contiguous from the top or the bottom of the array
  function automatic logic fpw_protected(input logic [4:0] bp, input logic [23:0] first,
                                         input logic [23:0] last);
    logic [23:0] span;
    span = (bp[BP_SMALL_BIT] ? SMALL_UNIT : BIG_UNIT) << (bp[2:0] - BP_ONE);
    if (bp[2:0] == BP_NONE) return 1'b0;
    if (bp[2:0] == BP_ALL) return 1'b1;
    if (bp[BP_BOTTOM_BIT]) return first < span;
    return last >= (24'h000000 - span);
  endfunction : fpw_protected

  // next read address: linear, or wrapped inside an 8/16/32/64 byte section
  function automatic logic [23:0] fpw_wrap_next(input logic [23:0] a, input logic en,
                                                input logic [1:0] code);
    logic [23:0] m;
    m = (WRAP_MIN_LEN << code) - ONE_24;
    if (!en) return a + ONE_24;
    return (a & ~m) | ((a + ONE_24) & m);
  endfunction : fpw_wrap_next

endpackage : fpw_pkg

// ==== logic/fpw_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fpw_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic [W-1:0] d_i, // asynchronous inputs
  output logic [W-1:0] q_o // synchronised outputs
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ----------
  // two flops; the first feeds only the second
  // ----------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : fpw_sync

// ==== logic/fpw_fifo.sv ====
// parameterised valid/ready fifo for program write-out words
`timescale 1ns/1ps
module fpw_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic in_valid_i, // write side valid
  output logic in_ready_o, // write side ready (not full)
  input wire logic [W-1:0] in_data_i, // write data
  output logic out_valid_o, // read side valid (not empty)
  input wire logic out_ready_i, // read side ready
  output logic [W-1:0] out_data_o // read data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [0:D-1];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // ----------
  // pointers carry an extra wrap bit so full and empty are exact
  // ----------
  assign in_ready_o = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = push ? wr_q + {{AW{1'b0}}, 1'b1} : wr_q;
    rd_d = pop ? rd_q + {{AW{1'b0}}, 1'b1} : rd_q;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset; it is only read behind a valid pointer
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule : fpw_fifo

// ==== logic/fpw_flash_seq.sv ====
// serial flash program, erase and wrap-setup sequencer (device side)
//
// Contract
// - wrap setup: 77H, 24 dummy bits, one wrap byte, then select rises.
// - wrap byte bit4 low enables wrap; bits 6:5 pick 8/16/32/64 bytes.
// - wrap setting persists for all later quad reads until disabled again.
// - wrapped reads restart at section start and run until select rises.
// - host bits are taken on rising serial clock edges.
// - program and erase need write enable latch set beforehand.
// - page program: 02H, three address bytes, at least one data byte.
// - low address byte increments and wraps inside the page.
// - over 256 bytes: only the last 256 are programmed.
// - under 256 bytes: untouched page bytes stay unchanged.
// - program runs only if select rises on a whole byte boundary.
// - select rise starts timed cycle; busy flag high until it ends.
// - write enable latch clears before the timed cycle ends.
// - no program into a protected page.
// - quad program 32H uses four data lines, needs quad enable bit.
// - 20H plus address erases the whole containing sector.
// - erase runs only if select rises right after third address byte.
// - no sector erase into a protected sector.
// - 52H erases the containing 32KB block unless protected.
// - D8H erases the containing 64KB block unless protected.
`timescale 1ns/1ps
module fpw_flash_seq #(
  parameter int PAGE_PROG_TIME_US = 600,
  parameter int SECT_CLEAR_TIME_US = 45000,
  parameter int HALF_BLOCK_CLEAR_TIME_US = 150000,
  parameter int FULL_BLOCK_CLEAR_TIME_US = 200000
) (
  input wire logic core_clk_i, // core clock, 10 MHz
  input wire logic reset_i, // async reset, active high
  input wire logic chip_select_n_i, // serial select pin, active low
  input wire logic serial_shift_clock_i, // serial clock pin
  input wire logic serial_in_line_i, // single-line serial data in
  input wire logic [3:0] quad_data_lines_i, // quad lines, input side
  output logic [3:0] quad_data_lines_o, // quad lines, output side
  output logic [3:0] quad_data_lines_oe_n_o, // quad lines enable, low drives
  input wire logic quad_enable_bit_i, // status bit 9
  input wire logic [4:0] block_protect_bits_i, // protection setting
  output logic write_in_progress_flag_o, // self-timed cycle busy
  output logic write_enable_latch_o, // write enable latch
  output logic wrap_enable_o, // wrap around on for quad reads
  output logic [1:0] wrap_length_code_o, // 0:8 1:16 2:32 3:64 bytes
  input wire logic read_start_i, // read engine loads start address
  input wire logic [23:0] read_addr_i, // start address of a read
  input wire logic read_step_i, // read engine consumed one byte
  output logic [23:0] read_addr_o, // current read byte address
  output logic mem_wr_valid_o, // program word valid
  input wire logic mem_wr_ready_i, // array accepts program word
  output logic [23:0] mem_wr_addr_o, // program byte address
  output logic [7:0] mem_wr_data_o, // program byte value
  output logic erase_req_o, // erase start, one-cycle pulse
  output logic [23:0] erase_addr_o, // erase base address
  output logic [1:0] erase_size_o // erase unit, fpw_erase_t
);
  localparam int PROG_CYC = PAGE_PROG_TIME_US * fpw_pkg::CLK_MHZ;
  localparam int SECT_CYC = SECT_CLEAR_TIME_US * fpw_pkg::CLK_MHZ;
  localparam int HALF_CYC = HALF_BLOCK_CLEAR_TIME_US * fpw_pkg::CLK_MHZ;
  localparam int FULL_CYC = FULL_BLOCK_CLEAR_TIME_US * fpw_pkg::CLK_MHZ;

  // ----------
  // pin synchronisation and edge detection
  // ----------
  logic [6:0] pins_s;
  logic cs_n_s, sclk_s, si_s;
  logic [3:0] qd_s;
  logic sclk_prev_q, cs_prev_q;
  logic sclk_rise, cs_rise, cs_fall;

  fpw_sync #(.W(7)) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i({!chip_select_n_i, serial_shift_clock_i, serial_in_line_i, quad_data_lines_i}),
    .q_o(pins_s)
  );

  // select travels inverted so the cleared synchroniser reads deselected after reset
  assign {cs_n_s, sclk_s, si_s, qd_s} = {!pins_s[6], pins_s[5:0]};
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign cs_rise = cs_n_s && !cs_prev_q;
  assign cs_fall = !cs_n_s && cs_prev_q;

  // this block never drives the quad lines
  assign quad_data_lines_o = 4'h0;
  assign quad_data_lines_oe_n_o = 4'hF;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // ----------
  // serial command decoder
  // ----------
  fpw_pkg::fpw_phase_t phase_q, phase_d;
  logic [5:0] cnt_q, cnt_d, cnt_n, step;
  logic [7:0] sh_q, sh_d, sh_in, opc_q, opc_d, wbyte_q, wbyte_d, ptr_q, ptr_d;
  logic [23:0] addr_q, addr_d;
  logic got_q, got_d, quad_now, buf_we;

  // bits are only taken while select is low; a high select rearms the opcode phase
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    opc_d = opc_q;
    wbyte_d = wbyte_q;
    ptr_d = ptr_q;
    addr_d = addr_q;
    got_d = got_q;
    buf_we = 1'b0;
    quad_now = (phase_q == fpw_pkg::PH_DATA) && (opc_q == fpw_pkg::OPC_QPROG);
    step = quad_now ? fpw_pkg::STEP_QUAD : fpw_pkg::STEP_SINGLE;
    sh_in = quad_now ? {sh_q[3:0], qd_s} : {sh_q[6:0], si_s};
    cnt_n = cnt_q + step;
    if (cs_n_s) begin
      phase_d = fpw_pkg::PH_OPC;
      cnt_d = '0;
      got_d = 1'b0;
    end else if (sclk_rise) begin
      sh_d = sh_in;
      cnt_d = cnt_n;
      case (phase_q)
        fpw_pkg::PH_OPC: begin
          if (cnt_n == fpw_pkg::OPC_BITS) begin
            opc_d = sh_in;
            cnt_d = '0;
            case (sh_in)
              fpw_pkg::OPC_WRAP: phase_d = fpw_pkg::PH_DUMMY;
              fpw_pkg::OPC_PROG, fpw_pkg::OPC_SECT,
              fpw_pkg::OPC_HALF, fpw_pkg::OPC_FULL: phase_d = fpw_pkg::PH_ADDR;
              fpw_pkg::OPC_QPROG: phase_d = quad_enable_bit_i ? fpw_pkg::PH_ADDR : fpw_pkg::PH_SKIP;
              fpw_pkg::OPC_WRITE_ENABLE_COMMAND: phase_d = fpw_pkg::PH_TAIL;
              default: phase_d = fpw_pkg::PH_SKIP;
            endcase
          end
        end
        fpw_pkg::PH_ADDR: begin
          addr_d = {addr_q[22:0], si_s};
          if (cnt_n == fpw_pkg::ADDR_BITS) begin
            cnt_d = '0;
            ptr_d = addr_d[7:0];
            phase_d = (opc_q == fpw_pkg::OPC_PROG || opc_q == fpw_pkg::OPC_QPROG) ?
                      fpw_pkg::PH_DATA : fpw_pkg::PH_TAIL;
          end
        end
        fpw_pkg::PH_DUMMY: begin
          if (cnt_n == fpw_pkg::DUMMY_BITS) begin
            cnt_d = '0;
            phase_d = fpw_pkg::PH_WBYTE;
          end
        end
        fpw_pkg::PH_WBYTE: begin
          if (cnt_n == fpw_pkg::BYTE_BITS) begin
            cnt_d = '0;
            wbyte_d = sh_in;
            phase_d = fpw_pkg::PH_TAIL;
          end
        end
        fpw_pkg::PH_DATA: begin
          if (cnt_n == fpw_pkg::BYTE_BITS) begin
            cnt_d = '0;
            buf_we = 1'b1;
            got_d = 1'b1;
            ptr_d = ptr_q + 8'h01;
          end
        end
        // any bit past a complete command spoils it
        default: phase_d = fpw_pkg::PH_SKIP;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= fpw_pkg::PH_OPC;
      cnt_q <= '0;
      sh_q <= '0;
      opc_q <= '0;
      wbyte_q <= '0;
      ptr_q <= '0;
      addr_q <= '0;
      got_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      wbyte_q <= wbyte_d;
      ptr_q <= ptr_d;
      addr_q <= addr_d;
      got_q <= got_d;
    end
  end

  // ----------
  // page buffer: later bytes overwrite earlier ones at the same offset
  // ----------
  logic [7:0] page_mem [0:255];
  logic [255:0] vld_q, vld_d;
  fpw_pkg::fpw_cyc_t cyc_q, cyc_d;
  logic idle;

  assign idle = cyc_q == fpw_pkg::CY_IDLE;

  // writes are held off while a cycle drains the buffer
  always_ff @(posedge core_clk_i) begin
    if (buf_we && idle) begin
      page_mem[ptr_q] <= sh_d;
    end
  end

  // ----------
  // command execution and self-timed cycle
  // ----------
  logic wip_q, wip_d, wel_q, wel_d, ereq_q, ereq_d, wen_q, wen_d;
  logic [1:0] wlen_q, wlen_d, esize_q, esize_d;
  logic [31:0] timer_q, timer_d;
  logic [7:0] idx_q, idx_d;
  logic [15:0] page_q, page_d;
  logic [23:0] eaddr_q, eaddr_d, emask, rd_q, rd_d;
  logic is_erase, prog_ok, erase_ok, fifo_in_ready, fifo_out_valid, push;

  assign push = (cyc_q == fpw_pkg::CY_FILL) && vld_q[idx_q];

  always_comb begin
    cyc_d = cyc_q;
    wip_d = wip_q;
    wel_d = wel_q;
    ereq_d = 1'b0;
    wen_d = wen_q;
    wlen_d = wlen_q;
    esize_d = esize_q;
    timer_d = (timer_q != 32'h0) ? timer_q - 32'h1 : timer_q;
    idx_d = idx_q;
    page_d = page_q;
    eaddr_d = eaddr_q;
    vld_d = vld_q;
    is_erase = 1'b1;
    emask = fpw_pkg::SECT_MASK;
    case (opc_q)
      fpw_pkg::OPC_SECT: emask = fpw_pkg::SECT_MASK;
      fpw_pkg::OPC_HALF: emask = fpw_pkg::HALF_MASK;
      fpw_pkg::OPC_FULL: emask = fpw_pkg::FULL_MASK;
      default: is_erase = 1'b0;
    endcase
    prog_ok = cs_rise && idle && phase_q == fpw_pkg::PH_DATA && got_q && cnt_q == 6'h00 &&
              wel_q && (opc_q == fpw_pkg::OPC_PROG || quad_enable_bit_i) &&
              !fpw_pkg::fpw_protected(block_protect_bits_i, addr_q & ~fpw_pkg::PAGE_MASK,
                                      addr_q | fpw_pkg::PAGE_MASK);
    erase_ok = cs_rise && idle && phase_q == fpw_pkg::PH_TAIL && is_erase && wel_q &&
               !fpw_pkg::fpw_protected(block_protect_bits_i, addr_q & ~emask, addr_q | emask);
    // a fresh select clears leftovers of an aborted program sequence
    if (cs_fall && idle) vld_d = '0;
    if (buf_we && idle) vld_d[ptr_q] = 1'b1;
    if (cs_rise && phase_q == fpw_pkg::PH_TAIL && opc_q == fpw_pkg::OPC_WRAP) begin
      wen_d = !wbyte_q[fpw_pkg::WRAP_OFF_BIT];
      wlen_d = wbyte_q[fpw_pkg::WRAP_LEN_MSB:fpw_pkg::WRAP_LEN_LSB];
    end
    if (cs_rise && idle && phase_q == fpw_pkg::PH_TAIL && opc_q == fpw_pkg::OPC_WRITE_ENABLE_COMMAND) wel_d = 1'b1;
    if (prog_ok) begin
      cyc_d = fpw_pkg::CY_FILL;
      wip_d = 1'b1;
      wel_d = 1'b0;
      timer_d = 32'(PROG_CYC - 1);
      idx_d = 8'h00;
      page_d = addr_q[23:8];
    end
    if (erase_ok) begin
      cyc_d = fpw_pkg::CY_WAIT;
      wip_d = 1'b1;
      wel_d = 1'b0;
      ereq_d = 1'b1;
      eaddr_d = addr_q & ~emask;
      case (opc_q)
        fpw_pkg::OPC_HALF: begin
          esize_d = fpw_pkg::ER_HALF;
          timer_d = 32'(HALF_CYC - 1);
        end
        fpw_pkg::OPC_FULL: begin
          esize_d = fpw_pkg::ER_FULL;
          timer_d = 32'(FULL_CYC - 1);
        end
        default: begin
          esize_d = fpw_pkg::ER_SECT;
          timer_d = 32'(SECT_CYC - 1);
        end
      endcase
    end
    case (cyc_q)
      fpw_pkg::CY_FILL: begin
        // only written offsets leave the buffer, so the rest of the page is untouched
        if (!push || fifo_in_ready) begin
          vld_d[idx_q] = 1'b0;
          idx_d = idx_q + 8'h01;
          if (idx_q == 8'hFF) cyc_d = fpw_pkg::CY_WAIT;
        end
      end
      fpw_pkg::CY_WAIT: begin
        // the cycle lasts at least the timed length and until the write-out drains
        if (timer_q == 32'h0 && !fifo_out_valid) begin
          cyc_d = fpw_pkg::CY_IDLE;
          wip_d = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_q <= fpw_pkg::CY_IDLE;
      wip_q <= 1'b0;
      wel_q <= 1'b0;
      ereq_q <= 1'b0;
      wen_q <= 1'b0;
      wlen_q <= 2'h0;
      esize_q <= 2'h0;
      timer_q <= '0;
      idx_q <= '0;
      page_q <= '0;
      eaddr_q <= '0;
      vld_q <= '0;
    end else begin
      cyc_q <= cyc_d;
      wip_q <= wip_d;
      wel_q <= wel_d;
      ereq_q <= ereq_d;
      wen_q <= wen_d;
      wlen_q <= wlen_d;
      esize_q <= esize_d;
      timer_q <= timer_d;
      idx_q <= idx_d;
      page_q <= page_d;
      eaddr_q <= eaddr_d;
      vld_q <= vld_d;
    end
  end

  // ----------
  // write-out fifo toward the array
  // ----------
  fpw_fifo #(.W(32), .D(16)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({page_q, idx_q, page_mem[idx_q]}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(mem_wr_ready_i),
    .out_data_o({mem_wr_addr_o, mem_wr_data_o})
  );

  // ----------
  // read address sequencer for quad reads
  // ----------
  // stepping stops once select is high, which ends the burst
  always_comb begin
    rd_d = rd_q;
    if (read_start_i) rd_d = read_addr_i;
    else if (read_step_i && !cs_n_s) rd_d = fpw_pkg::fpw_wrap_next(rd_q, wen_q, wlen_q);
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) rd_q <= '0;
    else rd_q <= rd_d;
  end

  assign mem_wr_valid_o = fifo_out_valid;
  assign write_in_progress_flag_o = wip_q;
  assign write_enable_latch_o = wel_q;
  assign wrap_enable_o = wen_q;
  assign wrap_length_code_o = wlen_q;
  assign read_addr_o = rd_q;
  assign erase_req_o = ereq_q;
  assign erase_addr_o = eaddr_q;
  assign erase_size_o = esize_q;
endmodule : fpw_flash_seq

// ==== verif/fpw_host.sv ====
// serial host model: select, serial clock and data lines
`timescale 1ns/1ps
module fpw_host (
  input wire logic core_clk_i, // core clock
  output logic cs_n_o, // select, active low
  output logic sclk_o, // serial clock, low between frames
  output logic si_o, // single data line
  output logic [3:0] quad_o // quad data lines
);
  // ----------
  // bus tasks
  // ----------
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
    quad_o = 4'h0;
  end
  // four core cycles a level keeps each half above the three-cycle floor
  task automatic tick();
    repeat (4) @(posedge core_clk_i);
    #1 sclk_o = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 sclk_o = 1'b0;
  endtask : tick
  task automatic open_frame();
    @(posedge core_clk_i);
    #1 cs_n_o = 1'b0;
  endtask : open_frame
  // msb first, or one nibble a clock on the quad lines
  task automatic put(input logic [31:0] v, input int n, input logic q);
    for (int i = n - 1; i >= 0; i -= (q ? 4 : 1)) begin
      if (q) quad_o = v[i -: 4];
      else si_o = v[i];
      tick();
    end
  endtask : put
  // released lines flip so a stale bit is never read as valid
  task automatic close_frame();
    repeat (4) @(posedge core_clk_i);
    #1 cs_n_o = 1'b1;
    si_o = ~si_o;
    quad_o = ~quad_o;
    repeat (12) @(posedge core_clk_i);
  endtask : close_frame
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
    open_frame();
    put({24'h000000, op}, 8, 1'b0);
    put({8'h00, a} >> (24 - n), n, 1'b0);
  endtask : cmd
endmodule : fpw_host

// ==== verif/fpw_flash_seq_asserts.sv ====
// port assertions of the sequencer
`timescale 1ns/1ps
module fpw_flash_seq_asserts (
  input wire logic core_clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic write_in_progress_flag_o, // busy
  input wire logic write_enable_latch_o, // latch
  input wire logic read_start_i, // read load
  input wire logic [23:0] read_addr_i, // load value
  input wire logic [23:0] read_addr_o, // read address
  input wire logic mem_wr_valid_o, // word valid
  input wire logic mem_wr_ready_i, // word taken
  input wire logic erase_req_o, // erase pulse
  input wire logic [23:0] erase_addr_o, // erase base
  input wire logic [1:0] erase_size_o // erase unit
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // an aligned base shows the whole unit is cleared whatever the offset
  property p_sect; erase_req_o && erase_size_o == 2'h0 |-> erase_addr_o[11:0] == 12'h000; endproperty
  a_sect: assert property (p_sect) else $error("sector base off");
  property p_half; erase_req_o && erase_size_o == 2'h1 |-> erase_addr_o[14:0] == 15'h0000; endproperty
  a_half: assert property (p_half) else $error("half block base off");
  property p_full; erase_req_o && erase_size_o == 2'h2 |-> erase_addr_o[15:0] == 16'h0000; endproperty
  a_full: assert property (p_full) else $error("full block base off");
  property p_pulse; erase_req_o |=> !erase_req_o; endproperty
  a_pulse: assert property (p_pulse) else $error("erase request too long");
  property p_armed; $rose(write_in_progress_flag_o) |-> $past(write_enable_latch_o); endproperty
  a_armed: assert property (p_armed) else $error("cycle without latch");
  property p_unlatch; $fell(write_in_progress_flag_o) |-> !write_enable_latch_o; endproperty
  a_unlatch: assert property (p_unlatch) else $error("latch outlived cycle");
  property p_busy; mem_wr_valid_o |-> write_in_progress_flag_o; endproperty
  a_busy: assert property (p_busy) else $error("write while idle");
  property p_load; read_start_i |=> read_addr_o == $past(read_addr_i); endproperty
  a_load: assert property (p_load) else $error("read start not loaded");
  c_erase: cover property (erase_req_o);
  c_write: cover property (mem_wr_valid_o && mem_wr_ready_i);
  c_stall: cover property (mem_wr_valid_o && !mem_wr_ready_i);
endmodule : fpw_flash_seq_asserts
bind fpw_flash_seq fpw_flash_seq_asserts u_chk (.core_clk_i, .reset_i, .write_in_progress_flag_o,
  .write_enable_latch_o, .read_start_i, .read_addr_i, .read_addr_o, .mem_wr_valid_o, .mem_wr_ready_i,
  .erase_req_o, .erase_addr_o, .erase_size_o);

// ==== verif/fpw_flash_seq_tb.sv ====
// self-checking bench of the program, erase and wrap sequencer
`timescale 1ns/1ps
module fpw_flash_seq_tb;
  typedef struct {logic [7:0] op; logic [23:0] a; logic [4:0] bp; logic [26:0] e;} fpw_row_t;
  logic clk = 1'b0, rst = 1'b1, qen = 1'b0, rs = 1'b0, st = 1'b0, rdy = 1'b0;
  logic cs_n, sclk, si, write_in_progress_flag, write_enable_latch, wen, wv, er;
  logic [3:0] qin, qo, oe_n;
  logic [4:0] bp = 5'h00;
  logic [23:0] ra = 24'h000000, ro, wa, ea;
  logic [7:0] wd;
  logic [1:0] wl, es;
  logic [26:0] cap = 27'h0;
  logic [31:0] wq[$];
  logic [31:0] pexp[3] = '{32'h000000C3, 32'h0000FEA1, 32'h0000FFB2};
  fpw_row_t rows[5] = '{'{8'h20, 24'h123456, 5'h00, {1'b1, 24'h123000, 2'h0}},
    '{8'hD8, 24'h12ABCD, 5'h00, {1'b1, 24'h120000, 2'h2}}, '{8'h20, 24'hFFF123, 5'h01, 27'h0},
    '{8'hD8, 24'h000010, 5'h09, 27'h0}, '{8'h52, 24'h12ABCD, 5'h00, {1'b1, 24'h128000, 2'h1}}};
  int failures = 0, n_tests = 0, cyc = 0;
  fpw_host u_host (.core_clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .quad_o(qin));
  fpw_flash_seq #(.PAGE_PROG_TIME_US(1), .SECT_CLEAR_TIME_US(2), .HALF_BLOCK_CLEAR_TIME_US(3),
    .FULL_BLOCK_CLEAR_TIME_US(4)) u_dut (.core_clk_i(clk), .reset_i(rst), .chip_select_n_i(cs_n),
    .serial_shift_clock_i(sclk), .serial_in_line_i(si), .quad_data_lines_i(qin), .quad_data_lines_o(qo),
    .quad_data_lines_oe_n_o(oe_n), .quad_enable_bit_i(qen), .block_protect_bits_i(bp),
    .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch), .wrap_enable_o(wen),
    .wrap_length_code_o(wl), .read_start_i(rs), .read_addr_i(ra), .read_step_i(st), .read_addr_o(ro),
    .mem_wr_valid_o(wv), .mem_wr_ready_i(rdy), .mem_wr_addr_o(wa), .mem_wr_data_o(wd),
    .erase_req_o(er), .erase_addr_o(ea), .erase_size_o(es));
  always #50 clk = ~clk;
  // ----------
  // helpers
  // ----------
  // log array traffic; ready drops every third cycle so the fifo must hold its head
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdy <= #1 (cyc % 3 != 0);
    if (wv === 1'b1 && rdy === 1'b1) wq.push_back({wa, wd});
    if (er === 1'b1) cap = {1'b1, ea, es};
    if (cyc > 40000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic settle();
    for (int i = 0; i < 3000 && write_in_progress_flag !== 1'b0; i++) @(posedge clk);
  endtask : settle
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d, input int n,
                      input logic q);
    u_host.cmd(op, a, (op == fpw_pkg::OPC_WRITE_ENABLE_COMMAND) ? 0 : 24);
    u_host.put(d, n, q);
    u_host.close_frame();
  endtask : prog
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ----------
  // tests
  // ----------
  initial begin
    repeat (5) @(posedge clk);
    chk({write_in_progress_flag, write_enable_latch, wen, oe_n, qo}, 32'hF0, "reset");
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      #1 bp = rows[i].bp;
      cap = 27'h0;
      prog(fpw_pkg::OPC_WRITE_ENABLE_COMMAND, 24'h0, 32'h0, 0, 1'b0);
      chk(write_enable_latch, 1'b1, "latch");
      u_host.cmd(rows[i].op, rows[i].a, 24);
      u_host.close_frame();
      settle();
      chk(cap, rows[i].e, "erase");
    end
    $display("test erase rows done");
    cap = 27'h0;
    prog(fpw_pkg::OPC_SECT, 24'h001000, 32'h0, 0, 1'b0);
    chk({cap[26], write_in_progress_flag}, 2'b00, "no latch");
    prog(fpw_pkg::OPC_WRITE_ENABLE_COMMAND, 24'h0, 32'h0, 0, 1'b0);
    u_host.cmd(fpw_pkg::OPC_SECT, 24'h001000, 23);
    u_host.close_frame();
    chk({cap[26], write_enable_latch}, 2'b01, "short erase");
    $display("test refused erase done");
    prog(fpw_pkg::OPC_PROG, 24'h0000FE, 32'h00A1B2C3, 24, 1'b0);
    chk({write_in_progress_flag, write_enable_latch}, 2'b10, "program start");
    settle();
    chk(wq.size(), 3, "count");
    foreach (pexp[i]) chk(wq[i], pexp[i], "word");
    prog(fpw_pkg::OPC_WRITE_ENABLE_COMMAND, 24'h0, 32'h0, 0, 1'b0);
    prog(fpw_pkg::OPC_PROG, 24'h000010, 32'h0ABC, 12, 1'b0);
    chk(write_in_progress_flag, 1'b0, "part byte");
    #1 bp = 5'h01;
    prog(fpw_pkg::OPC_PROG, 24'hFF0000, 32'h55, 8, 1'b0);
    chk(write_in_progress_flag, 1'b0, "protected");
    #1 bp = 5'h00;
    prog(fpw_pkg::OPC_QPROG, 24'h000040, 32'h5A, 8, 1'b1);
    chk(write_in_progress_flag, 1'b0, "quad off");
    #1 qen = 1'b1;
    wq.delete();
    prog(fpw_pkg::OPC_QPROG, 24'h000040, 32'h5A, 8, 1'b1);
    settle();
    chk(wq.size(), 1, "quad count");
    chk(wq[0], 32'h0000405A, "quad word");
    $display("test program done");
    for (int c = 3; c >= 0; c--) begin
      prog(fpw_pkg::OPC_WRAP, 24'h0, {25'h0, c[1:0], 5'h00}, 8, 1'b0);
      chk({wen, wl}, {1'b1, c[1:0]}, "wrap on");
    end
    u_host.open_frame();
    repeat (6) @(posedge clk);
    #1 ra = 24'h00001E;
    rs = 1'b1;
    @(posedge clk);
    #1 rs = 1'b0;
    st = 1'b1;
    repeat (2) @(posedge clk);
    #1 st = 1'b0;
    chk(ro, 24'h000018, "wrap read");
    u_host.close_frame();
    prog(fpw_pkg::OPC_WRAP, 24'h0, 32'h10, 8, 1'b0);
    chk(wen, 1'b0, "wrap off");
    $display("test wrap done");
    finish_test();
  end
endmodule : fpw_flash_seq_tb
